// ==== src/pdt_params.svh ====
`ifndef PDT_PARAMS_SVH
`define PDT_PARAMS_SVH

`define PDT_A_CTRL 8'h00
`define PDT_A_STAT 8'h04
`define PDT_A_STICKY 8'h08
`define PDT_A_CFG 8'h0C
`define PDT_A_AMASK 8'h10
`define PDT_A_CMASK 8'h14
`define PDT_A_POLY 8'h18
`define PDT_A_OSEL 8'h1C
`define PDT_A_REGS 8'h20
`define PDT_A_FIFO0 8'h40
`define PDT_A_FIFO1 8'h44
`define PDT_A_FSTAT 8'h48

`define PDT_CFG_MSB 0
`define PDT_CFG_CPAIR 3
`define PDT_CFG_CIN 5
`define PDT_CFG_TMUX 7
`define PDT_CFG_PRS 8
`define PDT_CFG_CHAIN 9
`define PDT_CFG_FDIR 10
`define PDT_CFG_DPCLK 12
`define PDT_CFG_SCCLK 14

`define PDT_CFG_RST 16'h5007
`define PDT_AMASK_RST 8'hFF
`define PDT_CMASK_RST 16'hFFFF
`define PDT_POLY_RST 8'hB8
`define PDT_FIFO_DEPTH 3'h4

`endif

// ==== src/pdt_pkg.sv ====
package pdt_pkg;
  typedef enum logic [2:0] {
    OP_PASS, OP_ADD, OP_SUB, OP_INC, OP_SHL, OP_SHR, OP_CRC, OP_FIFO
  } pdt_op_t;
  typedef enum logic [1:0] {CLK_OFF, CLK_ON, CLK_ROUTED} pdt_clk_t;
endpackage

// ==== src/pdt_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface pdt_link_if;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_rdata;
  logic [5:0] route_in;
  logic [5:0] route_out;
  logic [7:0] ctl;
  logic [7:0] stat;
  logic tile_en;
  logic chn_ci;
  logic chn_si;
  logic [2:0] chn_cond_i;
  logic chn_co;
  logic chn_so;
  logic [2:0] chn_cond_o;
  modport tile(input bus_addr, bus_wdata, bus_wr, bus_rd, route_in, stat, tile_en, chn_ci,
    chn_si, chn_cond_i, output bus_rdata, route_out, ctl, chn_co, chn_so, chn_cond_o);
  modport host(output bus_addr, bus_wdata, bus_wr, bus_rd, route_in, stat, tile_en, chn_ci,
    chn_si, chn_cond_i, input bus_rdata, route_out, ctl, chn_co, chn_so, chn_cond_o);
endinterface
`default_nettype wire

// ==== src/pdt_tile.sv ====
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "pdt_params.svh"
module pdt_tile
  import pdt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  pdt_link_if.tile lnk
);
  logic [7:0] ctrl_q, sticky_q, stat_q, amask_q, poly_q;
  logic [15:0] cfg_q, cmask_q;
  logic [23:0] osel_q;
  logic [31:0] rdata_q;
  logic [7:0] acc_q [2][2];
  logic [7:0] dat_q [2][2];
  logic set_q, cy_q, so_q, co_q;
  logic [5:0] rout_q;
  logic [2:0] chc_q;
  logic dp_en, sc_en, s, dst, f_k, sin, cin, fb, ov, co, so, ch, stat_rd, dp_fifo;
  logic [2:0] msb;
  logic [3:0] msb1;
  logic [7:0] wm, a, b, res, upd, clr;
  logic [8:0] sum;
  logic [15:0] cond;
  logic [7:0] cx [2];
  logic [7:0] cy [2];
  logic [1:0] ce, cl, zd, fd, f_push, f_pop, f_full, f_empty;
  logic [7:0] f_head [2];
  logic [7:0] f_wd [2];
  pdt_op_t op;

  function automatic logic clk_on(input logic [1:0] sel, input logic routed);
    case (sel)
      CLK_ON: return 1'b1;
      CLK_ROUTED: return routed;
      default: return 1'b0;
    endcase
  endfunction

  assign dp_en = clk_on(cfg_q[`PDT_CFG_DPCLK +: 2], lnk.tile_en);
  assign sc_en = clk_on(cfg_q[`PDT_CFG_SCCLK +: 2], lnk.tile_en);
  assign op = pdt_op_t'(lnk.route_in[2:0]);
  assign dst = lnk.route_in[4];
  assign f_k = lnk.route_in[5];
  assign s = cfg_q[`PDT_CFG_TMUX] & set_q;
  assign ch = cfg_q[`PDT_CFG_CHAIN];
  assign a = acc_q[s][dst];
  assign msb = cfg_q[`PDT_CFG_MSB +: 3];
  assign msb1 = {1'b0, msb} + 4'h1;
  assign wm = 8'hFF >> (3'h7 - msb);

  always_comb begin
    unique case (cfg_q[`PDT_CFG_CIN +: 2])
      2'h1: begin
        cin = cy_q;
        sin = so_q;
      end
      2'h2: begin
        cin = lnk.chn_ci;
        sin = lnk.chn_si;
      end
      default: begin
        cin = lnk.route_in[3];
        sin = lnk.route_in[3];
      end
    endcase
  end

  always_comb begin
    b = 8'h00;
    sum = 9'h000;
    res = a;
    co = cy_q;
    so = so_q;
    ov = 1'b0;
    fb = 1'b0;
    unique case (op)
      OP_PASS: ;
      OP_ADD, OP_SUB, OP_INC: begin
        b = (op == OP_ADD) ? dat_q[s][0] : (op == OP_SUB) ? ~dat_q[s][0] : 8'h00;
        b = b & wm;
        sum = {1'b0, a & wm} + {1'b0, b} + {8'h00, (op == OP_ADD) ? cin : 1'b1};
        res = sum[7:0];
        co = sum[msb1];
        ov = (a[msb] == b[msb]) && (sum[msb] != a[msb]);
      end
      OP_SHL: begin
        res = {a[6:0], sin};
        so = a[msb];
      end
      OP_SHR: begin
        res = (a >> 1) | ({7'h00, sin} << msb);
        so = a[0];
      end
      OP_CRC: begin
        fb = a[msb] ^ (sin & ~cfg_q[`PDT_CFG_PRS]);
        res = {a[6:0], 1'b0} ^ (fb ? poly_q : 8'h00);
        so = fb;
      end
      OP_FIFO: begin
        if (!cfg_q[`PDT_CFG_FDIR + f_k] && !f_empty[f_k]) begin
          res = f_head[f_k];
        end
      end
    endcase
    upd = (res & wm & amask_q) | (a & ~(wm & amask_q));
  end

  always_comb begin
    unique case (cfg_q[`PDT_CFG_CPAIR +: 2])
      2'h0: begin
        cx[0] = acc_q[s][0];
        cy[0] = dat_q[s][0];
        cx[1] = acc_q[s][1];
        cy[1] = dat_q[s][1];
      end
      2'h1: begin
        cx[0] = acc_q[s][0];
        cy[0] = acc_q[s][1];
        cx[1] = dat_q[s][0];
        cy[1] = dat_q[s][1];
      end
      default: begin
        cx[0] = acc_q[s][0];
        cy[0] = dat_q[s][1];
        cx[1] = acc_q[s][1];
        cy[1] = dat_q[s][0];
      end
    endcase
    for (int i = 0; i < 2; i++) begin
      ce[i] = ((cx[i] ^ cy[i]) & cmask_q[i*8 +: 8]) == 8'h00;
      cl[i] = (cx[i] & cmask_q[i*8 +: 8]) < (cy[i] & cmask_q[i*8 +: 8]);
      zd[i] = (acc_q[s][i] & wm) == 8'h00;
      fd[i] = (acc_q[s][i] | ~wm) == 8'hFF;
    end
  end

  always_comb begin
    cond = {s, f_full[1], f_empty[1], f_full[0], f_empty[0], so, co, ov,
      fd[1], fd[0] & (~ch | lnk.chn_cond_i[2]), zd[1], zd[0] & (~ch | lnk.chn_cond_i[1]),
      cl[1], cl[0], ce[1], ce[0] & (~ch | lnk.chn_cond_i[0])};
  end

  for (genvar g = 0; g < 6; g++) begin : g_rout
    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        rout_q[g] <= 1'b0;
      end else if (dp_en) begin
        rout_q[g] <= cond[osel_q[g*4 +: 4]];
      end
    end
  end
  assign lnk.route_out = rout_q;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      chc_q <= 3'h0;
      co_q <= 1'b0;
    end else if (dp_en) begin
      chc_q <= {cond[6], cond[4], cond[0]};
      co_q <= co;
    end
  end
  assign lnk.chn_cond_o = chc_q;
  assign lnk.chn_co = co_q;
  assign lnk.chn_so = so_q;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      acc_q <= '{default: 8'h00};
      dat_q <= '{default: 8'h00};
      set_q <= 1'b0;
      cy_q <= 1'b0;
      so_q <= 1'b0;
    end else begin
      if (dp_en) begin
        set_q <= cfg_q[`PDT_CFG_TMUX] ? ~set_q : 1'b0;
        if (op != OP_PASS) begin
          acc_q[s][dst] <= upd;
        end
        cy_q <= co;
        so_q <= so;
      end
      // Bus writes win over the datapath so firmware preloads are never lost.
      if (lnk.bus_wr && lnk.bus_addr[7:5] == `PDT_A_REGS >> 5) begin
        if (lnk.bus_addr[3]) begin
          acc_q[lnk.bus_addr[4]][lnk.bus_addr[2]] <= lnk.bus_wdata[7:0];
        end else begin
          dat_q[lnk.bus_addr[4]][lnk.bus_addr[2]] <= lnk.bus_wdata[7:0];
        end
      end
    end
  end

  assign dp_fifo = dp_en && op == OP_FIFO;
  for (genvar i = 0; i < 2; i++) begin : g_fifo
    logic [7:0] mem [4];
    logic [1:0] wp, rp;
    logic [2:0] cnt;
    logic dout, hit;
    assign dout = cfg_q[`PDT_CFG_FDIR + i];
    assign hit = lnk.bus_addr == (i ? `PDT_A_FIFO1 : `PDT_A_FIFO0);
    assign f_push[i] = dout ? dp_fifo && f_k == i : lnk.bus_wr && hit;
    assign f_pop[i] = dout ? lnk.bus_rd && hit : dp_fifo && f_k == i;
    assign f_wd[i] = dout ? a : lnk.bus_wdata[7:0];
    assign f_full[i] = cnt == `PDT_FIFO_DEPTH;
    assign f_empty[i] = cnt == 3'h0;
    assign f_head[i] = mem[rp];
    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        mem <= '{default: 8'h00};
        wp <= 2'h0;
        rp <= 2'h0;
        cnt <= 3'h0;
      end else begin
        if (f_push[i] && !f_full[i]) begin
          mem[wp] <= f_wd[i];
          wp <= wp + 2'h1;
        end
        if (f_pop[i] && !f_empty[i]) begin
          rp <= rp + 2'h1;
        end
        cnt <= cnt + {2'h0, f_push[i] && !f_full[i]} - {2'h0, f_pop[i] && !f_empty[i]};
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl_q <= 8'h00;
      sticky_q <= 8'h00;
      cfg_q <= `PDT_CFG_RST;
      amask_q <= `PDT_AMASK_RST;
      cmask_q <= `PDT_CMASK_RST;
      poly_q <= `PDT_POLY_RST;
      osel_q <= 24'h00_0000;
    end else if (lnk.bus_wr) begin
      case (lnk.bus_addr)
        `PDT_A_CTRL: ctrl_q <= lnk.bus_wdata[7:0];
        `PDT_A_STICKY: sticky_q <= lnk.bus_wdata[7:0];
        `PDT_A_CFG: cfg_q <= lnk.bus_wdata[15:0];
        `PDT_A_AMASK: amask_q <= lnk.bus_wdata[7:0];
        `PDT_A_CMASK: cmask_q <= lnk.bus_wdata[15:0];
        `PDT_A_POLY: poly_q <= lnk.bus_wdata[7:0];
        `PDT_A_OSEL: osel_q <= lnk.bus_wdata[23:0];
        default: ;
      endcase
    end
  end
  assign lnk.ctl = ctrl_q;

  assign stat_rd = lnk.bus_rd && lnk.bus_addr == `PDT_A_STAT;
  assign clr = {8{stat_rd}} & sticky_q;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      stat_q <= 8'h00;
    end else begin
      stat_q <= (sc_en ? lnk.stat : 8'h00) | (stat_q & ~clr & (sc_en ? sticky_q : 8'hFF));
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (lnk.bus_rd) begin
      rdata_q <= 32'h0000_0000;
      case (lnk.bus_addr)
        `PDT_A_CTRL: rdata_q[7:0] <= ctrl_q;
        `PDT_A_STAT: rdata_q[7:0] <= stat_q;
        `PDT_A_STICKY: rdata_q[7:0] <= sticky_q;
        `PDT_A_CFG: rdata_q[15:0] <= cfg_q;
        `PDT_A_AMASK: rdata_q[7:0] <= amask_q;
        `PDT_A_CMASK: rdata_q[15:0] <= cmask_q;
        `PDT_A_POLY: rdata_q[7:0] <= poly_q;
        `PDT_A_OSEL: rdata_q[23:0] <= osel_q;
        `PDT_A_FIFO0: rdata_q[7:0] <= f_head[0];
        `PDT_A_FIFO1: rdata_q[7:0] <= f_head[1];
        `PDT_A_FSTAT: rdata_q[3:0] <= {f_full[1], f_empty[1], f_full[0], f_empty[0]};
        default: begin
          if (lnk.bus_addr[7:5] == `PDT_A_REGS >> 5 && lnk.bus_addr[1:0] == 2'h0) begin
            rdata_q[7:0] <= lnk.bus_addr[3] ? acc_q[lnk.bus_addr[4]][lnk.bus_addr[2]] :
              dat_q[lnk.bus_addr[4]][lnk.bus_addr[2]];
          end
        end
      endcase
    end
  end
  assign lnk.bus_rdata = rdata_q;
endmodule
`default_nettype wire

// ==== src/pdt_host.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pdt_params.svh"
module pdt_host
  import pdt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  pdt_link_if.host lnk,
  input wire logic [7:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [31:0] sw_rdata_o,
  input wire logic [5:0] op_i,
  output logic [5:0] route_o,
  output logic [7:0] ctl_o,
  input wire logic [7:0] stat_i,
  input wire logic en_route_i,
  input wire logic [2:0] en_bit_i,
  input wire logic nb_ci_i,
  input wire logic nb_si_i,
  input wire logic [2:0] nb_cond_i,
  output logic nb_co_o,
  output logic nb_so_o,
  output logic [2:0] nb_cond_o
);
  logic [5:0] rin_q, rout_q;
  logic [7:0] stat_q, ctl_q;
  logic [2:0] ncond_q, cond_q;
  logic en_q, ci_q, si_q, co_q, so_q;

  // Bus strobes pass straight through so that read data stays one cycle behind the strobe.
  assign lnk.bus_addr = sw_addr_i;
  assign lnk.bus_wdata = sw_wdata_i;
  assign lnk.bus_wr = sw_wr_i;
  assign lnk.bus_rd = sw_rd_i;
  assign sw_rdata_o = lnk.bus_rdata;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rin_q <= 6'h00;
      stat_q <= 8'h00;
      en_q <= 1'b1;
    end else begin
      rin_q <= op_i;
      stat_q <= stat_i;
      en_q <= !en_route_i || lnk.ctl[en_bit_i];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ci_q <= 1'b0;
      si_q <= 1'b0;
      ncond_q <= 3'h7;
      co_q <= 1'b0;
      so_q <= 1'b0;
      cond_q <= 3'h0;
    end else begin
      ci_q <= nb_ci_i;
      si_q <= nb_si_i;
      ncond_q <= nb_cond_i;
      co_q <= lnk.chn_co;
      so_q <= lnk.chn_so;
      cond_q <= lnk.chn_cond_o;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rout_q <= 6'h00;
      ctl_q <= 8'h00;
    end else begin
      rout_q <= lnk.route_out;
      ctl_q <= lnk.ctl;
    end
  end

  assign lnk.route_in = rin_q;
  assign lnk.stat = stat_q;
  assign lnk.tile_en = en_q;
  assign lnk.chn_ci = ci_q;
  assign lnk.chn_si = si_q;
  assign lnk.chn_cond_i = ncond_q;
  assign route_o = rout_q;
  assign ctl_o = ctl_q;
  assign nb_co_o = co_q;
  assign nb_so_o = so_q;
  assign nb_cond_o = cond_q;
endmodule
`default_nettype wire

// ==== verification/pdt_link_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pdt_params.svh"
module pdt_link_props (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic [5:0] route_out,
  input wire logic [7:0] ctl,
  input wire logic [7:0] stat,
  input wire logic tile_en
);
  logic [7:0] wlow;
  assign wlow = bus_wdata[7:0];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  rdata_hold_a: assert property (
    !bus_rd |=> $stable(bus_rdata)) else $error("read data moved without a read");
  unmapped_read_a: assert property (
    bus_rd && bus_addr >= 8'h4C |=> bus_rdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");
  reset_clear_a: assert property (
    $fell(reset_i) |-> bus_rdata == 32'h0000_0000 && route_out == 6'h00 && ctl == 8'h00)
    else $error("outputs not cleared by reset");
  ctl_write_a: assert property (
    bus_wr && bus_addr == `PDT_A_CTRL |=> ctl == $past(wlow))
    else $error("control register missed a write");
  ctl_hold_a: assert property (
    !(bus_wr && bus_addr == `PDT_A_CTRL) |=> $stable(ctl))
    else $error("control register changed without a write");
  fifo_flags_a: assert property (
    bus_rd && bus_addr == `PDT_A_FSTAT |=> bus_rdata[31:4] == 28'h000_0000
    && !(bus_rdata[0] && bus_rdata[1]) && !(bus_rdata[2] && bus_rdata[3]))
    else $error("fifo reported full and empty together");
  stat_width_a: assert property (
    bus_rd && bus_addr == `PDT_A_STAT |=> bus_rdata[31:8] == 24'h00_0000)
    else $error("status read carried stray upper bits");
  tile_en_rst_a: assert property (
    $fell(reset_i) |-> tile_en) else $error("tile enable low after reset");
  cover property (bus_wr && bus_addr == `PDT_A_CTRL);
  cover property (bus_rd && bus_addr == `PDT_A_FSTAT ##1 bus_rdata[1]);
  cover property (bus_rd && bus_addr == `PDT_A_STAT ##1 bus_rdata[0]);
  cover property (stat[0] ##2 bus_rd && bus_addr == `PDT_A_STAT);
endmodule
`default_nettype wire

// ==== verification/tb_programmable_datapath_tile.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pdt_params.svh"
module tb_programmable_datapath_tile
  import pdt_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] sw_addr_i = 8'h00;
  logic [31:0] sw_wdata_i = 32'h0000_0000;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [31:0] sw_rdata_o;
  logic [5:0] op_i = 6'h00;
  logic [5:0] route_o;
  logic [7:0] ctl_o;
  logic [7:0] stat_i = 8'h00;
  logic en_route_i = 1'b0;
  logic [2:0] en_bit_i = 3'h0;
  logic nb_ci_i = 1'b0;
  logic nb_si_i = 1'b0;
  logic [2:0] nb_cond_i = 3'h7;
  logic nb_co_o;
  logic nb_so_o;
  logic [2:0] nb_cond_o;
  int err_count = 0;
  int num_checks = 0;
  pdt_link_if lnk();
  pdt_tile pdt_tile_i(.ref_clk_i(ref_clk_i), .reset_i(reset_i), .lnk(lnk));
  pdt_host pdt_host_i(.ref_clk_i(ref_clk_i), .reset_i(reset_i), .lnk(lnk),
    .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
    .sw_rdata_o(sw_rdata_o), .op_i(op_i), .route_o(route_o), .ctl_o(ctl_o), .stat_i(stat_i),
    .en_route_i(en_route_i), .en_bit_i(en_bit_i), .nb_ci_i(nb_ci_i), .nb_si_i(nb_si_i),
    .nb_cond_i(nb_cond_i), .nb_co_o(nb_co_o), .nb_so_o(nb_so_o), .nb_cond_o(nb_cond_o));
  pdt_link_props pdt_link_props_i(.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .bus_addr(lnk.bus_addr), .bus_wdata(lnk.bus_wdata), .bus_wr(lnk.bus_wr),
    .bus_rd(lnk.bus_rd), .bus_rdata(lnk.bus_rdata), .route_out(lnk.route_out),
    .ctl(lnk.ctl), .stat(lnk.stat), .tile_en(lnk.tile_en));

  always #25 ref_clk_i = ~ref_clk_i;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    sw_wr_i <= 1'b1;
    sw_addr_i <= a;
    sw_wdata_i <= d;
    @(posedge ref_clk_i);
    sw_wr_i <= 1'b0;
  endtask

  // Data are sampled at the edge that closes the cycle after the read, while they still stand,
  // so that every later stimulus of the calling test stays on a rising edge.
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    sw_rd_i <= 1'b1;
    sw_addr_i <= a;
    @(posedge ref_clk_i);
    sw_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(what, exp, sw_rdata_o);
  endtask

  // The op register in the host adds one cycle before the tile acts on it.
  task automatic run_op(input logic [5:0] op, input int n);
    @(posedge ref_clk_i);
    op_i <= op;
    repeat (n) @(posedge ref_clk_i);
    op_i <= 6'h00;
    repeat (3) @(posedge ref_clk_i);
  endtask

  task automatic t_reset;
    rd_chk("cfg", `PDT_A_CFG, 32'h0000_5007);
    rd_chk("amask", `PDT_A_AMASK, 32'h0000_00FF);
    rd_chk("cmask", `PDT_A_CMASK, 32'h0000_FFFF);
    rd_chk("poly", `PDT_A_POLY, 32'h0000_00B8);
    rd_chk("acc0", `PDT_A_REGS + 8'h08, 32'h0000_0000);
    rd_chk("unmapped", 8'h80, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_ctrl;
    en_route_i <= 1'b1;
    en_bit_i <= 3'h3;
    wr(`PDT_A_CTRL, 32'h0000_00A5);
    repeat (3) @(posedge ref_clk_i);
    chk("ctl", 32'h0000_00A5, {24'h00_0000, ctl_o});
    chk("tile_en", 32'h0000_0000, {31'h0, lnk.tile_en});
    en_bit_i <= 3'h0;
    repeat (2) @(posedge ref_clk_i);
    chk("tile_en", 32'h0000_0001, {31'h0, lnk.tile_en});
    en_route_i <= 1'b0;
    rd_chk("ctl read", `PDT_A_CTRL, 32'h0000_00A5);
    $display("test control done");
  endtask

  task automatic t_status;
    stat_i <= 8'h3C;
    repeat (3) @(posedge ref_clk_i);
    rd_chk("status", `PDT_A_STAT, 32'h0000_003C);
    wr(`PDT_A_STAT, 32'h0000_00FF);
    rd_chk("status ro", `PDT_A_STAT, 32'h0000_003C);
    stat_i <= 8'h00;
    wr(`PDT_A_STICKY, 32'h0000_0001);
    @(posedge ref_clk_i);
    stat_i <= 8'h01;
    @(posedge ref_clk_i);
    stat_i <= 8'h00;
    repeat (3) @(posedge ref_clk_i);
    rd_chk("sticky held", `PDT_A_STAT, 32'h0000_0001);
    rd_chk("sticky clear", `PDT_A_STAT, 32'h0000_0000);
    $display("test status done");
  endtask

  task automatic t_alu;
    wr(`PDT_A_REGS + 8'h08, 32'h0000_00FF);
    run_op({3'b000, OP_INC}, 1);
    rd_chk("inc wrap", `PDT_A_REGS + 8'h08, 32'h0000_0000);
    wr(`PDT_A_CFG, 32'h0000_5003);
    wr(`PDT_A_REGS + 8'h08, 32'h0000_00AF);
    run_op({3'b000, OP_INC}, 1);
    rd_chk("msb3 inc", `PDT_A_REGS + 8'h08, 32'h0000_00A0);
    wr(`PDT_A_CFG, 32'h0000_5007);
    wr(`PDT_A_AMASK, 32'h0000_00F0);
    wr(`PDT_A_REGS + 8'h08, 32'h0000_000F);
    run_op({3'b000, OP_INC}, 1);
    rd_chk("mask inc", `PDT_A_REGS + 8'h08, 32'h0000_001F);
    wr(`PDT_A_AMASK, 32'h0000_00FF);
    // Two back-to-back steps with time-mux on must land one in each set.
    wr(`PDT_A_CFG, 32'h0000_5087);
    wr(`PDT_A_REGS + 8'h08, 32'h0000_0010);
    wr(`PDT_A_REGS + 8'h18, 32'h0000_0010);
    run_op({3'b000, OP_INC}, 2);
    rd_chk("set0 acc", `PDT_A_REGS + 8'h08, 32'h0000_0011);
    rd_chk("set1 acc", `PDT_A_REGS + 8'h18, 32'h0000_0011);
    wr(`PDT_A_CFG, 32'h0000_5007);
    $display("test alu done");
  endtask

  task automatic t_fifo;
    wr(`PDT_A_OSEL, 32'h0000_000B);
    rd_chk("fstat", `PDT_A_FSTAT, 32'h0000_0005);
    chk("route f0empty", 32'h0000_0001, {31'h0, route_o[0]});
    for (int i = 1; i <= 5; i++) wr(`PDT_A_FIFO0, 32'(i * 17));
    rd_chk("fstat full", `PDT_A_FSTAT, 32'h0000_0006);
    chk("route f0empty", 32'h0000_0000, {31'h0, route_o[0]});
    // The fifth pop hits an empty buffer and must leave the accumulator alone.
    for (int i = 1; i <= 5; i++) begin
      run_op({3'b000, OP_FIFO}, 1);
      rd_chk("pop", `PDT_A_REGS + 8'h08, 32'((i < 5 ? i : 4) * 17));
    end
    rd_chk("fstat empty", `PDT_A_FSTAT, 32'h0000_0005);
    wr(`PDT_A_CFG, 32'h0000_5807);
    wr(`PDT_A_REGS + 8'h0C, 32'h0000_0099);
    run_op({3'b110, OP_FIFO}, 1);
    rd_chk("fstat out", `PDT_A_FSTAT, 32'h0000_0001);
    rd_chk("fifo1 read", `PDT_A_FIFO1, 32'h0000_0099);
    rd_chk("fstat drained", `PDT_A_FSTAT, 32'h0000_0005);
    $display("test fifo done");
  endtask

  task automatic t_chain;
    wr(`PDT_A_CFG, 32'h0000_5247);
    wr(`PDT_A_OSEL, 32'h0000_0049);
    wr(`PDT_A_REGS + 8'h00, 32'h0000_0001);
    wr(`PDT_A_REGS + 8'h08, 32'h0000_00FF);
    nb_ci_i <= 1'b1;
    run_op({3'b000, OP_ADD}, 1);
    rd_chk("chain add", `PDT_A_REGS + 8'h08, 32'h0000_0001);
    chk("carry route", 32'h0000_0001, {31'h0, route_o[0]});
    chk("carry out", 32'h0000_0001, {31'h0, nb_co_o});
    chk("zero route", 32'h0000_0000, {31'h0, route_o[1]});
    chk("chain eq", 32'h0000_0001, {31'h0, route_o[2]});
    chk("chain cond", 32'h0000_0001, {29'h0, nb_cond_o});
    nb_cond_i <= 3'h6;
    repeat (4) @(posedge ref_clk_i);
    chk("chain eq", 32'h0000_0000, {31'h0, route_o[2]});
    chk("chain cond", 32'h0000_0000, {29'h0, nb_cond_o});
    nb_cond_i <= 3'h7;
    nb_si_i <= 1'b1;
    run_op({3'b000, OP_SHL}, 1);
    rd_chk("chain shift", `PDT_A_REGS + 8'h08, 32'h0000_0003);
    nb_ci_i <= 1'b0;
    nb_si_i <= 1'b0;
    wr(`PDT_A_CFG, 32'h0000_5007);
    wr(`PDT_A_REGS + 8'h08, 32'h0000_0080);
    run_op({3'b000, OP_SHL}, 1);
    rd_chk("shift", `PDT_A_REGS + 8'h08, 32'h0000_0000);
    chk("zero route", 32'h0000_0001, {31'h0, route_o[1]});
    chk("shift out", 32'h0000_0001, {31'h0, nb_so_o});
    wr(`PDT_A_CFG, 32'h0000_5027);
    run_op({3'b000, OP_SHL}, 1);
    rd_chk("shift reuse", `PDT_A_REGS + 8'h08, 32'h0000_0001);
    $display("test chain done");
  endtask

  task automatic t_ops;
    wr(`PDT_A_CFG, 32'h0000_5007);
    wr(`PDT_A_REGS + 8'h08, 32'h0000_0081);
    run_op({3'b001, OP_CRC}, 1);
    rd_chk("crc step", `PDT_A_REGS + 8'h08, 32'h0000_0002);
    wr(`PDT_A_CFG, 32'h0000_5107);
    wr(`PDT_A_REGS + 8'h08, 32'h0000_0081);
    run_op({3'b001, OP_CRC}, 1);
    rd_chk("prs step", `PDT_A_REGS + 8'h08, 32'h0000_00BA);
    wr(`PDT_A_CFG, 32'h0000_5007);
    wr(`PDT_A_REGS + 8'h08, 32'h0000_0010);
    wr(`PDT_A_REGS + 8'h00, 32'h0000_0003);
    run_op({3'b000, OP_SUB}, 1);
    rd_chk("sub", `PDT_A_REGS + 8'h08, 32'h0000_000D);
    run_op({3'b001, OP_SHR}, 1);
    rd_chk("shr", `PDT_A_REGS + 8'h08, 32'h0000_0086);
    wr(`PDT_A_REGS + 8'h0C, 32'h0000_0086);
    chk("pair ne", 32'h0000_0000, {31'h0, route_o[2]});
    wr(`PDT_A_CFG, 32'h0000_500F);
    repeat (3) @(posedge ref_clk_i);
    chk("pair eq", 32'h0000_0001, {31'h0, route_o[2]});
    en_route_i <= 1'b1;
    en_bit_i <= 3'h3;
    wr(`PDT_A_CFG, 32'h0000_6007);
    run_op({3'b000, OP_INC}, 1);
    rd_chk("gated inc", `PDT_A_REGS + 8'h08, 32'h0000_0086);
    en_bit_i <= 3'h0;
    run_op({3'b000, OP_INC}, 1);
    rd_chk("enabled inc", `PDT_A_REGS + 8'h08, 32'h0000_0087);
    en_route_i <= 1'b0;
    wr(`PDT_A_CFG, 32'h0000_5007);
    $display("test ops done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_ctrl();
    t_status();
    t_alu();
    t_fifo();
    t_chain();
    t_ops();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    $display("Error watchdog expected done seen hang");
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
